// ==== rtl/lma_regs.v ====
// Purpose: Register bank for record front end level detector and two mic preamps
// Assumes: Control port gives 8-bit address, write strobe, read strobe on clk_i
// Notes:   Read data is registered one cycle after the read strobe
`include "lma_consts.vh"
`default_nettype none

module lma_regs #(
   parameter W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] addr_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire [4*W-1:0] mag_i,
   output wire [3:0] lvl_chan_en_o,
   output wire [6:0] lvl_thr_o,
   output wire anti_clip_o,
   output wire mic1_en_o,
   output wire mic1_mute_o,
   output wire [2:0] mic1_gain_o,
   output wire [1:0] mic1_sel_o,
   output wire mic2_en_o,
   output wire mic2_mute_o,
   output wire [2:0] mic2_gain_o,
   output wire [1:0] mic2_sel_o,
   output reg interrupt_out_n
);

   reg [3:0] lvl_en_q;
   reg [6:0] lvl_thr_q;
   reg mic1_en_q;
   reg mic1_mute_q;
   reg [2:0] mic1_gain_q;
   reg [1:0] mic1_sel_q;
   reg mic2_en_q;
   reg mic2_mute_q;
   reg [2:0] mic2_gain_q;
   reg [1:0] mic2_sel_q;
   reg event_q;
   reg mask_q;
   reg trip_q;
   wire trip;
   wire rise;
   reg [7:0] rd_d;

   // ----------------------------------------
   // Write side
   // ----------------------------------------
   function hit;
      input [7:0] a;
      input [7:0] reg_addr;
      begin
         hit = wr_i && (a == reg_addr);
      end
   endfunction

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvl_en_q <= `LMA_RST_LVL_EN;
         lvl_thr_q <= `LMA_RST_LVL_THR;
         mic1_en_q <= `LMA_RST_AMP_EN;
         mic1_mute_q <= `LMA_RST_AMP_MUTE;
         mic1_gain_q <= `LMA_RST_GAIN;
         mic1_sel_q <= `LMA_RST_SEL;
         mic2_en_q <= `LMA_RST_AMP_EN;
         mic2_mute_q <= `LMA_RST_AMP_MUTE;
         mic2_gain_q <= `LMA_RST_GAIN;
         mic2_sel_q <= `LMA_RST_SEL;
         mask_q <= 1'b0;
      end else begin
         // Only defined field bits are stored; the rest are dropped
         if (hit(addr_i, `LMA_ADDR_LVL_EN)) lvl_en_q <= wdata_i[3:0];
         if (hit(addr_i, `LMA_ADDR_LVL_THR)) lvl_thr_q <= wdata_i[6:0];
         if (hit(addr_i, `LMA_ADDR_MIC1_CTRL)) begin
            mic1_en_q <= wdata_i[`LMA_CTRL_EN_BIT];
            mic1_mute_q <= wdata_i[`LMA_CTRL_MUTE_BIT];
         end
         if (hit(addr_i, `LMA_ADDR_MIC1_GAIN)) mic1_gain_q <= wdata_i[2:0];
         if (hit(addr_i, `LMA_ADDR_MIC1_SEL)) mic1_sel_q <= wdata_i[1:0];
         if (hit(addr_i, `LMA_ADDR_MIC2_CTRL)) begin
            mic2_en_q <= wdata_i[`LMA_CTRL_EN_BIT];
            mic2_mute_q <= wdata_i[`LMA_CTRL_MUTE_BIT];
         end
         if (hit(addr_i, `LMA_ADDR_MIC2_GAIN)) mic2_gain_q <= wdata_i[2:0];
         if (hit(addr_i, `LMA_ADDR_MIC2_SEL)) mic2_sel_q <= wdata_i[1:0];
         if (hit(addr_i, `LMA_ADDR_EVENT_MASK)) mask_q <= wdata_i[`LMA_LVL_EVENT_BIT];
      end
   end

   // ----------------------------------------
   // Level detector and event
   // ----------------------------------------
   lma_level_det #(
      .W(W)
   ) u_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .chan_en_i(lvl_en_q),
      .thr_i(lvl_thr_q),
      .mag_i(mag_i),
      .anti_clip_o(anti_clip_o),
      .trip_o(trip)
   );

   // Event is the rising edge of a trip, so a steady overload raises it once
   assign rise = trip && !trip_q;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trip_q <= 1'b0;
         event_q <= 1'b0;
         interrupt_out_n <= 1'b1;
      end else begin
         trip_q <= trip;
         // Write one clears; a new event in the same cycle wins
         if (rise) begin
            event_q <= 1'b1;
         end else if (hit(addr_i, `LMA_ADDR_EVENT) && wdata_i[`LMA_LVL_EVENT_BIT]) begin
            event_q <= 1'b0;
         end
         interrupt_out_n <= !(event_q && !mask_q);
      end
   end

   // ----------------------------------------
   // Read side
   // ----------------------------------------
   always @* begin
      rd_d = 8'h00;
      case (addr_i)
         `LMA_ADDR_LVL_EN: rd_d = {4'h0, lvl_en_q};
         `LMA_ADDR_LVL_THR: rd_d = {1'b0, lvl_thr_q};
         `LMA_ADDR_MIC1_CTRL: rd_d = {mic1_en_q, mic1_mute_q, 6'h00};
         `LMA_ADDR_MIC1_GAIN: rd_d = {5'h00, mic1_gain_q};
         `LMA_ADDR_MIC1_SEL: rd_d = {6'h00, mic1_sel_q};
         `LMA_ADDR_MIC2_CTRL: rd_d = {mic2_en_q, mic2_mute_q, 6'h00};
         `LMA_ADDR_MIC2_GAIN: rd_d = {5'h00, mic2_gain_q};
         `LMA_ADDR_MIC2_SEL: rd_d = {6'h00, mic2_sel_q};
         `LMA_ADDR_EVENT: rd_d = {7'h00, event_q};
         `LMA_ADDR_EVENT_MASK: rd_d = {7'h00, mask_q};
         default: rd_d = 8'h00;
      endcase
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= rd_d;
      end
   end

   // Reserved select code 11 is passed through as stored; the analog side treats it as undefined
   assign lvl_chan_en_o = lvl_en_q;
   assign lvl_thr_o = lvl_thr_q;
   assign mic1_en_o = mic1_en_q;
   assign mic1_mute_o = mic1_mute_q;
   assign mic1_gain_o = mic1_gain_q;
   assign mic1_sel_o = mic1_sel_q;
   assign mic2_en_o = mic2_en_q;
   assign mic2_mute_o = mic2_mute_q;
   assign mic2_gain_o = mic2_gain_q;
   assign mic2_sel_o = mic2_sel_q;

endmodule

`default_nettype wire

// ==== rtl/lma_consts.vh ====
// Purpose: Offsets, field positions, reset values and codes for the level detect / mic amp bank
// Assumes: 8-bit register access with an 8-bit address
// Notes:   Definitions only
`ifndef LMA_CONSTS_VH
`define LMA_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LMA_ADDR_LVL_EN 8'h50
`define LMA_ADDR_LVL_THR 8'h51
`define LMA_ADDR_MIC1_CTRL 8'hb4
`define LMA_ADDR_MIC1_GAIN 8'hb5
`define LMA_ADDR_MIC1_SEL 8'hb7
`define LMA_ADDR_MIC2_CTRL 8'hb8
`define LMA_ADDR_MIC2_GAIN 8'hb9
`define LMA_ADDR_MIC2_SEL 8'hbb
`define LMA_ADDR_EVENT 8'hed
`define LMA_ADDR_EVENT_MASK 8'hee

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LMA_CTRL_EN_BIT 7
`define LMA_CTRL_MUTE_BIT 6
`define LMA_LVL_EVENT_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LMA_RST_LVL_EN 4'h0
`define LMA_RST_LVL_THR 7'h7f
`define LMA_RST_AMP_EN 1'h0
`define LMA_RST_AMP_MUTE 1'h1
`define LMA_RST_GAIN 3'h1
`define LMA_RST_SEL 2'h0

// ----------------------------------------
// Codes
// ----------------------------------------
`define LMA_SEL_DIFF 2'h0
`define LMA_SEL_POS 2'h1
`define LMA_SEL_NEG 2'h2
`define LMA_SEL_RSVD 2'h3

`endif

// ==== rtl/lma_level_det.v ====
// Purpose: Level comparator: any enabled channel above threshold raises anti-clip
// Assumes: Samples are unsigned magnitudes on the same clock, full scale = 2^W
// Notes:   Threshold code x means (x+1)/128 of full scale
`default_nettype none

module lma_level_det #(
   parameter W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] chan_en_i,
   input wire [6:0] thr_i,
   input wire [4*W-1:0] mag_i,
   output reg anti_clip_o,
   output wire trip_o
);

   // Scale (x+1)/128 into sample units: (x+1) << (W-7)
   wire [W:0] limit = {{(W-7){1'b0}}, {1'b0, thr_i} + 8'h01} << (W - 7);
   wire [3:0] over;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         assign over[g] = chan_en_i[g] && ({1'b0, mag_i[g*W +: W]} > limit);
      end
   endgenerate

   assign trip_o = |over;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         anti_clip_o <= 1'b0;
      end else begin
         anti_clip_o <= trip_o;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/lma_regs_assertions.sv ====
// Purpose: Port-level assertions for the level detect / mic amp bank
// Assumes: One clock, reset asynchronous and active high
// Notes:   Bound to lma_regs from the bench top
`default_nettype none
module lma_regs_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [3:0] lvl_chan_en_o,
   input wire logic [6:0] lvl_thr_o,
   input wire logic anti_clip_o,
   input wire logic mic1_en_o,
   input wire logic mic1_mute_o,
   input wire logic [2:0] mic1_gain_o,
   input wire logic mic2_en_o,
   input wire logic mic2_mute_o,
   input wire logic interrupt_out_n
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr(a); wr_i && addr_i == a; endsequence
   // A set in the same edge as the clear must win, so that case is excluded
   sequence s_clr; s_wr(8'hed) ##0 wdata_i[0] ##1 !$rose(anti_clip_o); endsequence
   a_chan_en_wr: assert property (s_wr(8'h50) |=> {4'h0, lvl_chan_en_o} == ($past(wdata_i) & 8'h0f))
      else $error("channel enables differ from write");
   a_thr_wr: assert property (s_wr(8'h51) |=> {1'h0, lvl_thr_o} == ($past(wdata_i) & 8'h7f))
      else $error("threshold differs from write");
   a_mic1_ctrl: assert property (s_wr(8'hb4) |=> {mic1_en_o, mic1_mute_o, 6'h0} == ($past(wdata_i) & 8'hc0))
      else $error("mic one enable or mute differs from write");
   a_mic2_ctrl: assert property (s_wr(8'hb8) |=> {mic2_en_o, mic2_mute_o, 6'h0} == ($past(wdata_i) & 8'hc0))
      else $error("mic two enable or mute differs from write");
   a_gain_hold: assert property (!(wr_i && addr_i == 8'hb5) |=> $stable(mic1_gain_o))
      else $error("mic one gain moved without a write");
   a_gain_rsvd: assert property (rd_i && (addr_i == 8'hb5 || addr_i == 8'hb9) |=> rdata_o[7:3] == 5'h0)
      else $error("reserved gain bits read nonzero");
   a_unmapped_rd: assert property (rd_i && addr_i == 8'h52 |=> rdata_o == 8'h00)
      else $error("unmapped read nonzero");
   a_irq_clear: assert property (s_clr |=> interrupt_out_n)
      else $error("interrupt still low after event clear");
endmodule
`default_nettype wire

// ==== testbench/test_lma_regs.sv ====
// Purpose: Self-checking bench for the level detect / mic amp bank
// Assumes: Read data settles one edge after the read strobe
// Notes:   Pins are gathered in one vector for compact compares
`default_nettype none
module test_lma_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   logic [63:0] mag_i = 64'h0;
   wire logic [7:0] rdata_o;
   wire logic [26:0] pins;
   int checks = 0, num_errors = 0, cycles = 0;
   // Address, write data, expected readback
   logic [23:0] rows [10] = '{24'h50ff0f, 24'h518000, 24'h513f3f, 24'hb4ffc0, 24'hb5ff07,
      24'hb7fe02, 24'hb84040, 24'hb90a02, 24'hbb0101, 24'h52ff00};
   lma_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .mag_i(mag_i), .lvl_chan_en_o(pins[26:23]), .lvl_thr_o(pins[22:16]),
      .mic1_en_o(pins[15]), .mic1_mute_o(pins[14]), .mic1_gain_o(pins[13:11]), .mic1_sel_o(pins[10:9]),
      .mic2_en_o(pins[8]), .mic2_mute_o(pins[7]), .mic2_gain_o(pins[6:4]), .mic2_sel_o(pins[3:2]),
      .anti_clip_o(pins[1]), .interrupt_out_n(pins[0]));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic complete_run;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         complete_run;
      end
   end
   task automatic chk(input string n, input logic [26:0] e, input logic [26:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Each access leaves one idle cycle so no strobe is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) #1;
      addr_i = a; wdata_i = d; wr_i = 1;
      @(posedge clk_i) #1 wr_i = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i) #1;
      addr_i = a; rd_i = 1;
      @(posedge clk_i) #1 rd_i = 0;
      chk("rdata", 27'(e), 27'(rdata_o));
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      #1 chk("reset pins", {4'h0, 7'h7f, 7'h24, 7'h24, 2'h1}, pins);
      rst_i = 0;
      rd(8'hb8, 8'h40);
      rd(8'hb9, 8'h01);
      for (int i = 0; i < 10; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      chk("pins", {4'hf, 7'h3f, 7'h7e, 7'h29, 2'h1}, pins);
      // Threshold 0x3f means a limit of 0x8000 at 16 bits; equal must not trip
      mag_i[63:48] = 16'h8000;
      repeat (3) @(posedge clk_i);
      #1 chk("at limit", 27'h1, 27'(pins[1:0]));
      mag_i[63:48] = 16'h8001;
      repeat (3) @(posedge clk_i);
      #1 chk("over limit", 27'h2, 27'(pins[1:0]));
      rd(8'hed, 8'h01);
      wr(8'h50, 8'h07);
      // Anti-clip is registered, so it drops one edge after the enable changes
      @(posedge clk_i) #1 chk("chan off", 27'h0, 27'(pins[1]));
      wr(8'hed, 8'h01);
      rd(8'hed, 8'h00);
      chk("irq cleared", 27'h1, 27'(pins[0]));
      wr(8'hee, 8'h01);
      rd(8'hee, 8'h01);
      wr(8'h50, 8'h0f);
      repeat (2) @(posedge clk_i);
      #1 chk("masked", 27'h3, 27'(pins[1:0]));
      rst_i = 1;
      @(posedge clk_i) #1 chk("mid reset", {4'h0, 7'h7f, 7'h24, 7'h24, 2'h1}, pins);
      rst_i = 0;
      rd(8'h51, 8'h7f);
      complete_run;
   end
endmodule
bind lma_regs lma_regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
   .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .lvl_chan_en_o(lvl_chan_en_o), .lvl_thr_o(lvl_thr_o),
   .anti_clip_o(anti_clip_o), .mic1_en_o(mic1_en_o), .mic1_mute_o(mic1_mute_o), .mic1_gain_o(mic1_gain_o),
   .mic2_en_o(mic2_en_o), .mic2_mute_o(mic2_mute_o), .interrupt_out_n(interrupt_out_n));
`default_nettype wire
